// *** rx_out_defs.svh ***
// Constants for the receive system-side output stage
`ifndef RX_OUT_DEFS_SVH
`define RX_OUT_DEFS_SVH

`define SYM_WORD_W      3
`define SYM_POS_BIT     2
`define SYM_NEG_BIT     1
`define SYM_VIOL_BIT    0
`define SYM_FIFO_DEPTH  8
`define EXZ_LIMIT       3
`define ZERO_CNT_W      4
`define VIOL_CNT_W      8
`define DUAL_RAIL_RST   1'b1
`define OUT_RST         1'b0

`endif

// *** rx_out_pkg.sv ***
// Types shared by the receive output stage
package rx_out_pkg;
   typedef enum logic [0:0] {
      RAIL_SINGLE = 1'b0,
      RAIL_DUAL   = 1'b1
   } rail_mode_t;

   typedef logic [2:0] sym_word_t;
endpackage : rx_out_pkg

// *** rx_side_output.sv ***
// Receive output stage: line classification, symbol FIFO and framer-side outputs
//
// What this block does
// - Dual rail: negative symbols go on negative output
// - Dual rail: negative pulse gives one-cycle high
// - Single rail: violation or excess zeros pulse output
// - Negative/violation output changes only on recovered edge
// - Recovered clock driven out; outputs launched on it
// - Tip above ring positive; below ring negative
// - Dual rail: positive pulse gives one-cycle high
// - Single rail: all data on positive output

`include "rx_out_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module sym_fifo #(
   parameter int WIDTH = `SYM_WORD_W,
   parameter int DEPTH = `SYM_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Fill side
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   // Drain side
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_out = (count_reg != '0);
   assign out_data_out  = mem[rd_ptr_reg];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : ptr_inc

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   chk_fifo_no_over: assert property (@(posedge clk_in) disable iff (rst_in)
      count_reg == (AW+1)'(DEPTH) |-> !in_ready_out)
      else $error("fifo accepted while full");
endmodule : sym_fifo

////////////////////////////////////////////////////////////////////////////////
module rx_side_output #(
   parameter int EXZ_LIMIT  = `EXZ_LIMIT,
   parameter int FIFO_DEPTH = `SYM_FIFO_DEPTH
) (
   // System clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   // System-side control
   input  wire rx_out_pkg::rail_mode_t rail_mode_in,
   input  wire logic                 framer_hold_in,
   output logic                      violation_seen_out,
   // Line side, recovered clock domain
   input  wire logic                 line_clk_in,
   input  wire logic                 line_in_plus,
   input  wire logic                 line_in_minus,
   output logic                      line_accept_out,
   // Framer outputs
   output logic                      recovered_clock_out,
   output logic                      pos_data_out,
   output logic                      neg_data_or_violation_out
);
   import rx_out_pkg::*;

   localparam int ZW = `ZERO_CNT_W;
   localparam int VW = `VIOL_CNT_W;

   function automatic logic [VW-1:0] to_gray(input logic [VW-1:0] b);
      to_gray = b ^ (b >> 1);
   endfunction : to_gray

   // System-domain control registers
   rail_mode_t mode_reg;
   logic       hold_reg;
   logic [VW-1:0] viol_gray_meta_reg, viol_gray_sync_reg, viol_done_reg;
   logic       violation_seen_reg;

   // Link-domain state
   logic       plus_meta_reg, plus_sync_reg;
   logic       minus_meta_reg, minus_sync_reg;
   logic       dual_meta_reg, dual_sync_reg;
   logic       hold_meta_reg, hold_sync_reg;
   logic       have_pulse_reg;
   logic       last_neg_reg;
   logic [ZW-1:0] zero_cnt_reg;
   logic       pos_data_reg;
   logic       neg_data_reg;
   logic       out_dual_reg;
   logic [VW-1:0] viol_cnt_reg, viol_gray_reg;

   logic       pos_pulse, neg_pulse, line_code_violation, excess_zero_event, viol_pending;
   sym_word_t  push_word, fifo_word;
   logic       fifo_valid, fifo_pop;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_reg <= RAIL_DUAL;
         hold_reg <= 1'b0;
      end else begin
         mode_reg <= rail_mode_in;
         hold_reg <= framer_hold_in;
      end
   end

   // Count crosses in gray code: bursts faster than this clock are owed, not lost
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         viol_gray_meta_reg <= '0;
         viol_gray_sync_reg <= '0;
         viol_done_reg      <= '0;
         violation_seen_reg <= 1'b0;
      end else begin
         viol_gray_meta_reg <= viol_gray_reg;
         viol_gray_sync_reg <= viol_gray_meta_reg;
         viol_done_reg      <= viol_done_reg + VW'(viol_pending);
         violation_seen_reg <= viol_pending;
      end
   end
   assign viol_pending = (viol_gray_sync_reg != to_gray(viol_done_reg));
   assign violation_seen_out = violation_seen_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Line pins and system levels each pass two flops on the recovered clock
   always_ff @(posedge line_clk_in or posedge rst_in) begin
      if (rst_in) begin
         plus_meta_reg  <= 1'b0;
         plus_sync_reg  <= 1'b0;
         minus_meta_reg <= 1'b0;
         minus_sync_reg <= 1'b0;
         dual_meta_reg  <= `DUAL_RAIL_RST;
         dual_sync_reg  <= `DUAL_RAIL_RST;
         hold_meta_reg  <= 1'b0;
         hold_sync_reg  <= 1'b0;
      end else begin
         plus_meta_reg  <= line_in_plus;
         plus_sync_reg  <= plus_meta_reg;
         minus_meta_reg <= line_in_minus;
         minus_sync_reg <= minus_meta_reg;
         dual_meta_reg  <= mode_reg;
         dual_sync_reg  <= dual_meta_reg;
         hold_meta_reg  <= hold_reg;
         hold_sync_reg  <= hold_meta_reg;
      end
   end

   // Equal levels on both legs carry no pulse
   assign pos_pulse = plus_sync_reg & ~minus_sync_reg;
   assign neg_pulse = minus_sync_reg & ~plus_sync_reg;

   // Two pulses in a row of one polarity break the bipolar pattern
   assign line_code_violation = have_pulse_reg & ((neg_pulse & last_neg_reg) | (pos_pulse & ~last_neg_reg));
   assign excess_zero_event = ~pos_pulse & ~neg_pulse & (zero_cnt_reg == ZW'(EXZ_LIMIT - 1));

   always_ff @(posedge line_clk_in or posedge rst_in) begin
      if (rst_in) begin
         have_pulse_reg <= 1'b0;
         last_neg_reg   <= 1'b0;
         zero_cnt_reg   <= '0;
      end else if (pos_pulse | neg_pulse) begin
         have_pulse_reg <= 1'b1;
         last_neg_reg   <= neg_pulse;
         zero_cnt_reg   <= '0;
      end else if (zero_cnt_reg != ZW'(EXZ_LIMIT)) begin
         zero_cnt_reg   <= zero_cnt_reg + ZW'(1);
      end
   end

   assign push_word = {pos_pulse, neg_pulse, line_code_violation | excess_zero_event};

   // Bit periods cannot stall; a full FIFO drops symbols and shows it
   sym_fifo #(
      .WIDTH (`SYM_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (line_clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (1'b1),
      .in_data_in    (push_word),
      .in_ready_out  (line_accept_out),
      .out_valid_out (fifo_valid),
      .out_data_out  (fifo_word),
      .out_ready_in  (~hold_sync_reg)
   );
   assign fifo_pop = fifo_valid & ~hold_sync_reg;

   // Single-rail violations are counted as they leave the buffer
   always_ff @(posedge line_clk_in or posedge rst_in) begin
      if (rst_in) begin
         viol_cnt_reg  <= '0;
         viol_gray_reg <= '0;
      end else if (fifo_pop && !dual_sync_reg && fifo_word[`SYM_VIOL_BIT]) begin
         viol_cnt_reg  <= viol_cnt_reg + VW'(1);
         viol_gray_reg <= to_gray(viol_cnt_reg + VW'(1));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs launched on the recovered clock edge only
   always_ff @(posedge line_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pos_data_reg <= `OUT_RST;
         neg_data_reg <= `OUT_RST;
         out_dual_reg <= `DUAL_RAIL_RST;
      end else begin
         out_dual_reg <= dual_sync_reg;
         if (!fifo_pop) begin
            pos_data_reg <= 1'b0;
            neg_data_reg <= 1'b0;
         end else if (dual_sync_reg) begin
            pos_data_reg <= fifo_word[`SYM_POS_BIT];
            neg_data_reg <= fifo_word[`SYM_NEG_BIT];
         end else begin
            pos_data_reg <= fifo_word[`SYM_POS_BIT] | fifo_word[`SYM_NEG_BIT];
            neg_data_reg <= fifo_word[`SYM_VIOL_BIT];
         end
      end
   end

   assign recovered_clock_out       = line_clk_in;
   assign pos_data_out              = pos_data_reg;
   assign neg_data_or_violation_out = neg_data_reg;

   ////////////////////////////////////////////////////////////////////////////
   chk_neg_dual_map: assert property (@(posedge line_clk_in) disable iff (rst_in)
      fifo_pop && dual_sync_reg |=> neg_data_reg == $past(fifo_word[`SYM_NEG_BIT]))
      else $error("negative symbol not on negative output");
   chk_neg_one_cycle: assert property (@(posedge line_clk_in) disable iff (rst_in)
      neg_data_reg && out_dual_reg |-> $past(fifo_pop) && $past(fifo_word[`SYM_NEG_BIT]))
      else $error("negative output high without a negative symbol");
   chk_viol_single: assert property (@(posedge line_clk_in) disable iff (rst_in)
      fifo_pop && !dual_sync_reg && fifo_word[`SYM_VIOL_BIT] |=> neg_data_reg)
      else $error("violation not indicated");
   chk_neg_idle_low: assert property (@(posedge line_clk_in) disable iff (rst_in)
      !fifo_pop |=> !neg_data_reg && !pos_data_reg)
      else $error("output changed without a symbol");
   chk_pos_dual_map: assert property (@(posedge line_clk_in) disable iff (rst_in)
      fifo_pop && dual_sync_reg |=> pos_data_reg == $past(fifo_word[`SYM_POS_BIT]))
      else $error("positive symbol not on positive output");
   chk_pos_single: assert property (@(posedge line_clk_in) disable iff (rst_in)
      fifo_pop && !dual_sync_reg && (fifo_word[`SYM_POS_BIT] || fifo_word[`SYM_NEG_BIT]) |=> pos_data_reg)
      else $error("single rail data missing");
   chk_line_polarity: assert property (@(posedge line_clk_in) disable iff (rst_in)
      $past(line_in_plus, 2) && !$past(line_in_minus, 2) |-> push_word[`SYM_POS_BIT] && !push_word[`SYM_NEG_BIT])
      else $error("tip above ring not positive");
   chk_exz_flag: assert property (@(posedge line_clk_in) disable iff (rst_in)
      (pos_pulse || neg_pulse) ##1 (!pos_pulse && !neg_pulse) [*3] |-> push_word[`SYM_VIOL_BIT])
      else $error("excess zeros not flagged");
   chk_lcv_flag: assert property (@(posedge line_clk_in) disable iff (rst_in)
      neg_pulse ##1 (!pos_pulse && !neg_pulse) ##0 (zero_cnt_reg == '0) ##1 neg_pulse |-> push_word[`SYM_VIOL_BIT])
      else $error("repeated polarity not flagged");

   cov_dual_neg: cover property (@(posedge line_clk_in) disable iff (rst_in)
      out_dual_reg && neg_data_reg);
   cov_single_viol: cover property (@(posedge line_clk_in) disable iff (rst_in)
      !out_dual_reg && neg_data_reg);
   cov_fifo_full: cover property (@(posedge line_clk_in) disable iff (rst_in)
      !line_accept_out);
endmodule : rx_side_output

// *** framer_model.sv ***
// Framer-side model: counts pulses and flags output changes away from the recovered edge
module framer_model (
   // Reset and recovered clock
   input wire logic rst_in,
   input wire logic recovered_clock_in,
   // Receive data
   input wire logic pos_in,
   input wire logic neg_in
);
   timeunit 1ns;
   timeprecision 100ps;
   int pos_count;
   int neg_count;
   int off_edge;
   realtime t_rise;
   initial begin
      pos_count = 0;
      neg_count = 0;
      off_edge = 0;
      t_rise = 0;
   end
   always @(posedge recovered_clock_in) t_rise = $realtime;
   // Sampled mid-cycle so the launch edge never races the capture
   always @(negedge recovered_clock_in) begin
      if (pos_in === 1'b1) pos_count++;
      if (neg_in === 1'b1) neg_count++;
   end
   // Async reset may clear outputs at any time, so it is excused
   always @(pos_in or neg_in) begin
      if (!rst_in && ($realtime - t_rise) > 1.0) off_edge++;
   end
endmodule : framer_model

// *** rx_side_output_tb.sv ***
// Self-checking testbench for the receive output stage
module rx_side_output_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import rx_out_pkg::*;
   logic       clk_in, rst_in, line_clk_in, line_in_plus, line_in_minus, framer_hold_in;
   rail_mode_t rail_mode_in;
   logic       violation_seen_out, line_accept_out, recovered_clock_out, pos_data_out, neg_data_or_violation_out;
   int         failures, num_checks, cycles, viol_seen;
   logic [1:0] seq[$];

   rx_side_output dut (.clk_in(clk_in), .rst_in(rst_in), .rail_mode_in(rail_mode_in),
      .framer_hold_in(framer_hold_in), .violation_seen_out(violation_seen_out), .line_clk_in(line_clk_in),
      .line_in_plus(line_in_plus), .line_in_minus(line_in_minus), .line_accept_out(line_accept_out),
      .recovered_clock_out(recovered_clock_out), .pos_data_out(pos_data_out),
      .neg_data_or_violation_out(neg_data_or_violation_out));
   framer_model model (.rst_in(rst_in), .recovered_clock_in(recovered_clock_out), .pos_in(pos_data_out),
      .neg_in(neg_data_or_violation_out));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 0;
      forever #25 clk_in = ~clk_in;
   end
   initial begin
      line_clk_in = 0;
      #2.3;
      forever #3 line_clk_in = ~line_clk_in;
   end
   // Mid-cycle so the count never races the launching edge
   always @(negedge clk_in) begin
      if (violation_seen_out === 1'b1) viol_seen++;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : check

   // Single rail: repeated polarity is a violation, third zero of a run is one
   function automatic void expect_of(input logic [1:0] s[$], input bit single, output int ep, output int en);
      bit last_pos = 1;
      int zr = 0;
      ep = 0;
      en = 0;
      foreach (s[i]) begin
         if (s[i] == 2'b10 || s[i] == 2'b01) begin
            ep += (single || s[i] == 2'b10);
            en += single ? ((s[i] == 2'b10) == last_pos) : (s[i] == 2'b01);
            last_pos = (s[i] == 2'b10);
            zr = 0;
         end else begin
            zr++;
            if (single && zr == `EXZ_LIMIT) en++;
         end
      end
   endfunction : expect_of

   task automatic drive(input logic [1:0] q[$]);
      foreach (q[i]) begin
         @(posedge line_clk_in);
         #1 {line_in_plus, line_in_minus} = q[i];
      end
      @(posedge line_clk_in);
      #1 {line_in_plus, line_in_minus} = 2'b00;
   endtask : drive

   task automatic do_reset(input rail_mode_t m);
      #1 rail_mode_in = m;
      rst_in = 1;
      repeat (6) @(posedge clk_in);
      #1 rst_in = 0;
   endtask : do_reset

   task automatic run(input bit single, input int n);
      int p0, n0, v0, ep, en;
      // Priming pulse fixes the last polarity before counting starts
      seq = {2'b10};
      repeat (20) seq.push_back(2'b00);
      drive(seq);
      p0 = model.pos_count;
      n0 = model.neg_count;
      v0 = viol_seen;
      seq = {2'b10, 2'b10, 2'b01, 2'b01, 2'b00, 2'b11, 2'b00, 2'b00, 2'b10};
      repeat (n) seq.push_back(2'($urandom_range(3)));
      repeat (30) seq.push_back(2'b00);
      expect_of(seq, single, ep, en);
      drive(seq);
      check("recovered clock", recovered_clock_out, 1'b1);
      // Violations reach the system side at most one per system cycle
      repeat (80) @(posedge clk_in);
      check("pos pulses", model.pos_count - p0, ep);
      check("neg pulses", model.neg_count - n0, en);
      check("violations seen", viol_seen - v0, single ? en : 0);
      $display("test %s done", single ? "single rail" : "dual rail");
   endtask : run

   task automatic close_out();
      check("off-edge changes", model.off_edge, 0);
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int p0;
      rst_in = 1;
      rail_mode_in = RAIL_DUAL;
      framer_hold_in = 0;
      line_in_plus = 0;
      line_in_minus = 0;
      void'($urandom(32'h0ceb));
      do_reset(RAIL_DUAL);
      run(0, 60);
      // Stall the framer until idle words fill the buffer, then offer pulses
      @(posedge clk_in);
      #1 framer_hold_in = 1;
      repeat (10) @(posedge clk_in);
      check("accept while full", line_accept_out, 1'b0);
      p0 = model.pos_count;
      drive({2'b10, 2'b10, 2'b10, 2'b10, 2'b10});
      @(posedge clk_in);
      #1 framer_hold_in = 0;
      repeat (10) @(posedge clk_in);
      check("dropped pulses", model.pos_count - p0, 0);
      check("accept after drain", line_accept_out, 1'b1);
      $display("test buffer full done");
      do_reset(RAIL_SINGLE);
      run(1, 60);
      close_out();
   end
endmodule : rx_side_output_tb
